// ---- hdl/pin_select_pkg.sv ----
// shared constants and types for the port B low pin function select
package pin_select_pkg;
  localparam int NUM_PINS = 5;
  localparam int FIELD_W = 2;
  localparam int FIELD_STRIDE = 2;
  localparam int CTRL_W = 10;
  localparam logic [3:0] OFS_FUNC_SEL = 4'h0;
  localparam logic [3:0] OFS_GPIO_DIR = 4'h4;
  localparam logic [3:0] OFS_GPIO_OUT = 4'h8;
  localparam logic [3:0] OFS_PIN_STATE = 4'hC;
  localparam logic [CTRL_W-1:0] FUNC_SEL_RESET = 10'h000;
  localparam logic [NUM_PINS-1:0] GPIO_DIR_RESET = 5'h00;
  localparam logic [NUM_PINS-1:0] GPIO_OUT_RESET = 5'h00;

  typedef enum logic [1:0] {
    MODE_GPIO = 2'h0,
    MODE_RSVD = 2'h1,
    MODE_TIMER = 2'h2,
    MODE_PATTERN = 2'h3
  } pin_mode_t;

  // one timer capture/compare line as seen by a pin
  typedef struct packed {
    logic out;
    logic oe;
  } cc_pin_t;
endpackage

// ---- hdl/port_b_low_pin_function_select.sv ----
// pin function multiplexer for port B pins 4..0 with avalon register slave
// Notes on behaviour
// R1 - bits 9,8 select pin 4 function; 00 is general I/O, loaded at reset.
// R2 - pin 4: 10 routes timer channel 4 line A, 11 pattern bit 4.
// R3 - software never writes the reserved code 01 into any field.
// R4 - bits 7,6 select pin 3 function; 00 is general I/O at reset.
// R5 - pin 3: 10 routes timer channel 3 line B, 11 pattern bit 3.
// R6 - bits 5,4 select pin 2 function; 00 is general I/O at reset.
// R7 - pin 2: 10 routes timer channel 3 line A, 11 pattern bit 2.
// R8 - bits 3,2 select pin 1 function; 00 is general I/O at reset.
// R9 - pin 1: 10 routes timer channel 2 line B, 11 pattern bit 1.
// R10 - bits 1,0 select pin 0 function; 00 is general I/O at reset.
// R11 - peripheral functions own pin drive and enable, not the GPIO settings.
`timescale 1ns/1ps
`default_nettype none
module port_b_low_pin_function_select (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [4:0] pin_in,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe,
  input wire pin_select_pkg::cc_pin_t [4:1] timer_cc,
  output logic [4:1] timer_cc_in,
  input wire logic [4:1] pattern_out
);
  logic [pin_select_pkg::CTRL_W-1:0] func_sel, next_func_sel;
  logic [4:0] gpio_dir, next_gpio_dir;
  logic [4:0] gpio_out, next_gpio_out;
  logic [31:0] next_readdata;
  logic ack, next_ack;
  logic [4:0] next_pin_out, next_pin_oe;
  logic [4:1] next_timer_cc_in;
  logic take;
  logic [31:0] merged;

  function automatic pin_select_pkg::pin_mode_t mode_of(
    input logic [pin_select_pkg::CTRL_W-1:0] sel, input int pin);
    return pin_select_pkg::pin_mode_t'(
      sel[pin*pin_select_pkg::FIELD_STRIDE +: pin_select_pkg::FIELD_W]);
  endfunction

  // merge a written word into a register, honouring byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // one wait state: taken on the first cycle, answered on the second
  assign take = (read || write) && !ack;
  assign waitrequest = (read || write) && !ack;

  always_comb begin
    next_ack = take;
    next_func_sel = func_sel;
    next_gpio_dir = gpio_dir;
    next_gpio_out = gpio_out;
    next_readdata = readdata;
    merged = 32'h0000_0000;
    // a write lands at the accepting edge, when waitrequest is low
    if (ack && write) begin
      unique case (address)
        pin_select_pkg::OFS_FUNC_SEL: begin
          merged = merge({22'h0, func_sel}, writedata, byteenable);
          next_func_sel = merged[pin_select_pkg::CTRL_W-1:0]; // see R1
        end
        pin_select_pkg::OFS_GPIO_DIR: begin
          merged = merge({27'h0, gpio_dir}, writedata, byteenable);
          next_gpio_dir = merged[4:0];
        end
        pin_select_pkg::OFS_GPIO_OUT: begin
          merged = merge({27'h0, gpio_out}, writedata, byteenable);
          next_gpio_out = merged[4:0];
        end
        default: ;
      endcase
    end
    if (take && read) begin
      unique case (address)
        pin_select_pkg::OFS_FUNC_SEL: next_readdata = {22'h0, func_sel};
        pin_select_pkg::OFS_GPIO_DIR: next_readdata = {27'h0, gpio_dir};
        pin_select_pkg::OFS_GPIO_OUT: next_readdata = {27'h0, gpio_out};
        pin_select_pkg::OFS_PIN_STATE: next_readdata = {27'h0, pin_in};
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // pin drive; reserved code releases the pin rather than guess a source
  always_comb begin
    next_timer_cc_in = 4'h0;
    for (int p = 0; p < 5; p++) begin
      next_pin_out[p] = gpio_out[p]; // see R1 R4 R6 R8 R10
      next_pin_oe[p] = gpio_dir[p];
      if (mode_of(func_sel, p) == pin_select_pkg::MODE_RSVD) begin
        next_pin_out[p] = 1'b0;
        next_pin_oe[p] = 1'b0;
      end
    end
    // pin 0 has no peripheral line here, so its upper codes stay general I/O
    for (int p = 1; p < 5; p++) begin
      unique case (mode_of(func_sel, p))
        pin_select_pkg::MODE_GPIO, pin_select_pkg::MODE_RSVD: ;
        pin_select_pkg::MODE_TIMER: begin
          next_pin_out[p] = timer_cc[p].out; // see R2 R5 R7 R9 R11
          next_pin_oe[p] = timer_cc[p].oe;
          next_timer_cc_in[p] = pin_in[p];
        end
        pin_select_pkg::MODE_PATTERN: begin
          next_pin_out[p] = pattern_out[p]; // see R2 R5 R7 R9 R11
          next_pin_oe[p] = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      func_sel <= pin_select_pkg::FUNC_SEL_RESET; // see R1 R4 R6 R8 R10
      gpio_dir <= pin_select_pkg::GPIO_DIR_RESET;
      gpio_out <= pin_select_pkg::GPIO_OUT_RESET;
      readdata <= 32'h0000_0000;
      ack <= 1'b0;
      pin_out <= 5'h00;
      pin_oe <= 5'h00;
      timer_cc_in <= 4'h0;
    end else begin
      func_sel <= next_func_sel;
      gpio_dir <= next_gpio_dir;
      gpio_out <= next_gpio_out;
      readdata <= next_readdata;
      ack <= next_ack;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      timer_cc_in <= next_timer_cc_in;
    end
  end

  property p_pin4_gpio;
    @(posedge clock) disable iff (!rst_n)
    $past(func_sel[9:8]) == 2'h0 |->
      pin_oe[4] == $past(gpio_dir[4]) && pin_out[4] == $past(gpio_out[4]);
  endproperty
  a_pin4_gpio: assert property (p_pin4_gpio) // see R1
    else $error("pin4 gpio");
  property p_pin4_periph;
    @(posedge clock) disable iff (!rst_n)
    ($past(func_sel[9:8]) == 2'h2 |-> pin_out[4] == $past(timer_cc[4].out))
    and ($past(func_sel[9:8]) == 2'h3 |-> pin_out[4] == $past(pattern_out[4]));
  endproperty
  a_pin4_periph: assert property (p_pin4_periph) // see R2
    else $error("pin4 per");
  property p_pin3_gpio;
    @(posedge clock) disable iff (!rst_n)
    $past(func_sel[7:6]) == 2'h0 |-> pin_oe[3] == $past(gpio_dir[3]);
  endproperty
  a_pin3_gpio: assert property (p_pin3_gpio) // see R4
    else $error("pin3 gpio");
  property p_pin3_periph;
    @(posedge clock) disable iff (!rst_n)
    $past(func_sel[7:6]) == 2'h2 |-> pin_out[3] == $past(timer_cc[3].out);
  endproperty
  a_pin3_periph: assert property (p_pin3_periph) // see R5
    else $error("pin3 per");
  property p_pin3_pattern;
    @(posedge clock) disable iff (!rst_n)
    $past(func_sel[7:6]) == 2'h3 |->
      pin_oe[3] && pin_out[3] == $past(pattern_out[3]);
  endproperty
  a_pin3_pattern: assert property (p_pin3_pattern) // see R5
    else $error("pin3 pattern");
  property p_pin2_gpio;
    @(posedge clock) disable iff (!rst_n)
    $past(func_sel[5:4]) == 2'h0 |-> pin_out[2] == $past(gpio_out[2]);
  endproperty
  a_pin2_gpio: assert property (p_pin2_gpio) // see R6
    else $error("pin2 gpio");
  property p_pin2_periph;
    @(posedge clock) disable iff (!rst_n)
    $past(func_sel[5:4]) == 2'h3 |->
      pin_oe[2] && pin_out[2] == $past(pattern_out[2]);
  endproperty
  a_pin2_periph: assert property (p_pin2_periph) // see R7
    else $error("pin2 per");
  property p_pin2_timer;
    @(posedge clock) disable iff (!rst_n)
    $past(func_sel[5:4]) == 2'h2 |->
      pin_out[2] == $past(timer_cc[2].out) && pin_oe[2] == $past(timer_cc[2].oe);
  endproperty
  a_pin2_timer: assert property (p_pin2_timer) // see R7
    else $error("pin2 timer");
  property p_pin1_gpio;
    @(posedge clock) disable iff (!rst_n)
    $past(func_sel[3:2]) == 2'h0 |-> pin_oe[1] == $past(gpio_dir[1]);
  endproperty
  a_pin1_gpio: assert property (p_pin1_gpio) // see R8
    else $error("pin1 gpio");
  property p_pin1_periph;
    @(posedge clock) disable iff (!rst_n)
    $past(func_sel[3:2]) == 2'h2 |-> timer_cc_in[1] == $past(pin_in[1]);
  endproperty
  a_pin1_periph: assert property (p_pin1_periph) // see R9
    else $error("pin1 per");
  property p_pin1_pattern;
    @(posedge clock) disable iff (!rst_n)
    $past(func_sel[3:2]) == 2'h3 |->
      pin_oe[1] && pin_out[1] == $past(pattern_out[1]);
  endproperty
  a_pin1_pattern: assert property (p_pin1_pattern) // see R9
    else $error("pin1 pattern");
  property p_pin0_gpio;
    @(posedge clock) disable iff (!rst_n)
    $past(func_sel[1:0]) == 2'h0 |-> pin_out[0] == $past(gpio_out[0]);
  endproperty
  a_pin0_gpio: assert property (p_pin0_gpio) // see R10
    else $error("pin0 gpio");
  property p_periph_owns_oe;
    @(posedge clock) disable iff (!rst_n)
    $past(func_sel[9:8]) == 2'h2 |-> pin_oe[4] == $past(timer_cc[4].oe);
  endproperty
  a_periph_owns_oe: assert property (p_periph_owns_oe) // see R11
    else $error("oe src");
  property p_bus_answer;
    @(posedge clock) disable iff (!rst_n)
    (read || write) |-> ##[0:1] !waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("no bus answer");

  c_timer: cover property (@(posedge clock) func_sel[9:8] == 2'h2);
  c_pattern: cover property (@(posedge clock) func_sel[3:2] == 2'h3);
  c_read: cover property (@(posedge clock) read && !waitrequest);
endmodule // port_b_low_pin_function_select
`default_nettype wire

// ---- sim/port_b_low_pin_function_select_test.sv ----
// self-checking bench for the port B low pin function select
`timescale 1ns/1ps
`default_nettype none
module port_b_low_pin_function_select_test;
  localparam logic [4:0] DIR = 5'h1B;
  localparam logic [4:0] GOUT = 5'h15;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic [4:0] pin_in = 5'h00;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  pin_select_pkg::cc_pin_t [4:1] timer_cc = '0;
  logic [4:1] timer_cc_in;
  logic [4:1] pattern_out = 4'h0;
  int errors = 0;
  int checks = 0;
  logic [31:0] q;
  logic [2:0] m;
  logic [1:0] e;

  always #12.5 clock = ~clock;

  port_b_low_pin_function_select u_port_b_low_pin_function_select (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .timer_cc(timer_cc),
    .timer_cc_in(timer_cc_in), .pattern_out(pattern_out)
  );

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // sample waitrequest at the rising edge; one idle cycle keeps strobes apart
  task automatic bus(input logic we, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    logic w;
    n = 0;
    address <= a;
    writedata <= d;
    read <= ~we;
    write <= we;
    do begin
      @(posedge clock);
      w = waitrequest;
      q = readdata;
      n++;
    end while (w !== 1'b0 && n < 20);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
    if (w !== 1'b0) begin
      errors++;
      report_and_stop();
    end
  endtask

  // {oe,out} of pin i; pin 0 has no peripheral, so its upper codes act as gpio
  function automatic logic [1:0] want(input logic [1:0] c, input int i);
    if (i == 0 && c[1]) c = 2'h0;
    case (c)
      2'h0: want = {DIR[i], GOUT[i]};
      2'h2: want = {timer_cc[i].oe, timer_cc[i].out};
      2'h3: want = {1'b1, pattern_out[i]};
      default: want = 2'h0;
    endcase
  endfunction

  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, pin_select_pkg::OFS_FUNC_SEL, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 4'h1, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, pin_select_pkg::OFS_GPIO_DIR, {27'h0, DIR});
    bus(1'b1, pin_select_pkg::OFS_GPIO_OUT, {27'h0, GOUT});
    $display("test reset done");
    for (m = 3'h0; m < 3'h4; m++) begin
      if (m == 3'h1) begin
        continue;
      end
      bus(1'b1, pin_select_pkg::OFS_FUNC_SEL, {22'h3FFFFF, {5{m[1:0]}}});
      bus(1'b0, pin_select_pkg::OFS_FUNC_SEL, 32'h0);
      chk(q, {22'h0, {5{m[1:0]}}});
      for (int k = 0; k < 2; k++) begin
        pattern_out <= k ? 4'h5 : 4'hA;
        timer_cc <= k ? 8'h9C : 8'h63;
        pin_in <= k ? 5'h0A : 5'h15;
        repeat (2) @(negedge clock);
        for (int i = 0; i < 5; i++) begin
          e = want(m[1:0], i);
          chk({pin_oe[i], pin_out[i]}, e);
        end
        chk(timer_cc_in, m == 3'h2 ? pin_in[4:1] : 4'h0);
        @(posedge clock);
      end
      $display("test mode %0d done", m);
    end
    bus(1'b0, pin_select_pkg::OFS_PIN_STATE, 32'h0);
    chk(q, 32'h0A);
    $display("test pin state done");
    report_and_stop();
  end
endmodule // port_b_low_pin_function_select_test
`default_nettype wire
